// ==== design/sfd_pkg.sv ====
// constants for the sfd timing, pin routing and tx clock phase block
// assumes a 100 MHz register clock and a 16-bit register view on a 32-bit bus
package sfd_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] SFD_IDX_PSEL = 10'h03E;
  localparam logic [9:0] SFD_IDX_TCFG = 10'h040;
  localparam logic [9:0] SFD_IDX_PHASE = 10'h042;
  localparam logic [9:0] SFD_ADDR_PSEL = 10'(SFD_IDX_PSEL * 4);
  localparam logic [9:0] SFD_ADDR_TCFG = 10'(SFD_IDX_TCFG * 4);
  localparam logic [9:0] SFD_ADDR_PHASE = 10'(SFD_IDX_PHASE * 4);
  // pin select fields
  localparam int SFD_PSEL_TX_LSB = 4;
  localparam int SFD_PSEL_RX_LSB = 0;
  localparam logic [2:0] SFD_PSEL_RST = 3'h0;
  localparam logic [2:0] SFD_PIN_OFF = 3'h7;
  localparam logic [2:0] SFD_PIN_ACT = 3'h1;
  localparam logic [2:0] SFD_PIN_SPEED = 3'h2;
  localparam logic [2:0] SFD_PIN_LINK = 3'h3;
  localparam logic [2:0] SFD_PIN_CRS = 3'h4;
  localparam logic [2:0] SFD_PIN_COL = 3'h5;
  localparam logic [2:0] SFD_PIN_PDINT = 3'h6;
  // timing config fields
  localparam int SFD_TCFG_TX_LSB = 13;
  localparam int SFD_TCFG_RX_LSB = 10;
  localparam int SFD_TCFG_ERR_LSB = 8;
  localparam logic [2:0] SFD_OFF_RST = 3'h5;
  localparam logic [7:0] SFD_TCFG_LOW_RST = 8'h44;
  localparam logic [1:0] SFD_ERR_NONE = 2'h0;
  localparam logic [1:0] SFD_ERR_ACT = 2'h1;
  localparam logic [1:0] SFD_ERR_POWERDOWN_PIN = 2'h2;
  localparam logic [1:0] SFD_ERR_COL = 2'h3;
  // phase register fields
  localparam int SFD_PH_EN_BIT = 4;
  localparam logic [3:0] SFD_PH_RST = 4'h0;
  localparam logic [3:0] SFD_PH_MAX = 4'hA;
  // timing
  localparam int SFD_CLK_NS = 10;
  localparam int SFD_OFF_STEP_NS = 8;
  localparam int SFD_PH_STEP_NS = 4;
  localparam int SFD_DLY_TAPS = 8;
  localparam logic [15:0] SFD_ZERO16 = 16'h0000;
endpackage : sfd_pkg

// ==== design/sfd_timing_and_txclk_phase.sv ====
// sfd pulse routing, sfd timing offsets, tx error pin select, tx clock phase
// assumes sfd events arrive as one-cycle pulses on link_clk, pin functions
// and registers on ref_clk; srst and link_rst synchronous to their clocks
//
// Behaviour
// - tx pin select bits 6:4 route the tx sfd pulse to act, speed, link, crs, col or pdint pin, 111 turns it off.
// - rx pin select bits 2:0 route the rx sfd pulse with the same codes, 111 turns it off.
// - pin select bits 15:7 and 3 ignore writes and read zero.
// - timing bits 15:13 delay the tx sfd pulse in 8 ns steps, reset 101.
// - timing bits 12:10 delay the rx sfd pulse in 8 ns steps, reset 101.
// - timing bits 9:8 pick the tx error input pin: none, act, powerdown or col, reset from trim.
// - the tx clock keeps a fixed phase to the reference clock, moved only by the phase controls.
// - the phase value counts 4 ns units and software writes 0 to 10.
// - a written phase above 10 is stored and used modulo 10.
// - phase bit 4 self-clears, writing 1 applies the phase value, reset 0.
// - phase bits 3:0 hold the current phase, a new value moves the clock by 4 ns per step of difference; the code uses phase*4 ns floored to 10 ns cycles.
// - phase bits 15:5 ignore writes and read zero.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module sfd_timing_and_txclk_phase #(
  parameter logic [1:0] TXERR_TRIM = 2'h0,
  parameter int TXCLK_DIV = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic link_rst,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sfd events from the link side
  input wire logic tx_sfd_seen,
  input wire logic rx_sfd_seen,
  // normal pin functions
  input wire logic act_fn,
  input wire logic speed_fn,
  input wire logic link_fn,
  input wire logic crs_fn,
  input wire logic col_fn,
  input wire logic pdint_fn,
  // pins
  input wire logic activity_led_pin_i,
  output logic activity_led_pin_o,
  output logic activity_led_pin_oe,
  output logic speed_led_pin_o,
  output logic link_led_pin_o,
  output logic crs_pin_o,
  input wire logic col_pin_i,
  output logic col_pin_o,
  output logic col_pin_oe,
  input wire logic powerdown_interrupt_pin_i,
  output logic powerdown_interrupt_pin_o,
  output logic powerdown_interrupt_pin_oe,
  // tx error and tx clock
  output logic tx_err,
  output logic tx_clk,
  output logic [3:0] tx_phase_applied
);
  import sfd_pkg::*;

  localparam int DLY_W = $clog2(SFD_DLY_TAPS);
  localparam int DIV_W = $clog2(TXCLK_DIV);

  typedef struct packed {
    logic wait_q;
    logic [31:0] rdata;
    logic [2:0] tx_sel;
    logic [2:0] rx_sel;
    logic [2:0] tx_off;
    logic [2:0] rx_off;
    logic [1:0] err_sel;
    logic [7:0] tcfg_low;
    logic [3:0] ph_val;
    logic ph_en;
    logic [3:0] ph_app;
    logic [DIV_W-1:0] div_cnt;
    logic clk_out;
    logic [2:0] tx_sync;
    logic [2:0] rx_sync;
    logic [SFD_DLY_TAPS-1:0] tx_dly;
    logic [SFD_DLY_TAPS-1:0] rx_dly;
    logic [5:0] pin_o;
    logic [2:0] pin_oe;
    logic [2:0] err_s1;
    logic [2:0] err_s2;
    logic err_out;
  } sfd_ref_s;

  typedef struct packed {
    logic tx_tgl;
    logic rx_tgl;
  } sfd_link_s;

  sfd_ref_s q;
  sfd_ref_s d;
  sfd_link_s lq;
  sfd_link_s ld;

  // offset steps to ref cycles, rounded up so the pulse is never early
  function automatic logic [DLY_W-1:0] sfd_dly_cycles(input logic [2:0] off);
    int ns;
    ns = int'(off) * SFD_OFF_STEP_NS;
    sfd_dly_cycles = DLY_W'((ns + SFD_CLK_NS - 1) / SFD_CLK_NS);
  endfunction : sfd_dly_cycles

  // phase in ref cycles; the 10 ns grid only approximates 4 ns steps
  function automatic logic [DIV_W-1:0] sfd_ph_cycles(input logic [3:0] ph);
    int ns;
    ns = int'(ph) * SFD_PH_STEP_NS;
    sfd_ph_cycles = DIV_W'((ns / SFD_CLK_NS) % TXCLK_DIV);
  endfunction : sfd_ph_cycles

  // pulse onto a pin if the pin select code names it
  function automatic logic sfd_route(
    input logic [2:0] code,
    input logic [2:0] tx_sel,
    input logic [2:0] rx_sel,
    input logic tx_p,
    input logic rx_p,
    input logic fn
  );
    if (tx_sel == code && tx_p)
    begin
      sfd_route = 1'b1;
    end
    else if (rx_sel == code && rx_p)
    begin
      sfd_route = 1'b1;
    end
    else if (tx_sel == code || rx_sel == code)
    begin
      sfd_route = 1'b0;
    end
    else
    begin
      sfd_route = fn;
    end
  endfunction : sfd_route

  // link domain: each sfd event flips a toggle for the crossing
  always_comb
  begin
    ld = lq;
    ld.tx_tgl = lq.tx_tgl ^ tx_sfd_seen;
    ld.rx_tgl = lq.rx_tgl ^ rx_sfd_seen;
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      lq <= '0;
    end
    else
    begin
      lq <= ld;
    end
  end

  logic [15:0] wmask;
  logic [15:0] wnew;
  logic [15:0] rd_psel;
  logic [15:0] rd_tcfg;
  logic [15:0] rd_phase;
  logic [3:0] ph_w;
  logic tx_pulse;
  logic rx_pulse;
  logic take;

  always_comb
  begin
    d = q;
    wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wnew = avs_writedata[15:0];
    ph_w = wnew[3:0];
    take = (avs_read || avs_write) && q.wait_q;

    // reserved bits read zero
    rd_psel = SFD_ZERO16;
    rd_psel[SFD_PSEL_TX_LSB +: 3] = q.tx_sel;
    rd_psel[SFD_PSEL_RX_LSB +: 3] = q.rx_sel;
    rd_tcfg = {q.tx_off, q.rx_off, q.err_sel, q.tcfg_low};
    rd_phase = SFD_ZERO16;
    rd_phase[SFD_PH_EN_BIT] = q.ph_en;
    rd_phase[3:0] = q.ph_val;

    // bus: one cycle of waitrequest, then a one-cycle answer
    d.wait_q = 1'b1;
    d.ph_en = 1'b0;
    if (take)
    begin
      d.wait_q = 1'b0;
      d.rdata = '0;
      if (avs_address == SFD_ADDR_PSEL)
      begin
        if (avs_read)
        begin
          d.rdata[15:0] = rd_psel;
        end
        else if (wmask[0])
        begin
          d.tx_sel = wnew[SFD_PSEL_TX_LSB +: 3];
          d.rx_sel = wnew[SFD_PSEL_RX_LSB +: 3];
        end
      end
      else if (avs_address == SFD_ADDR_TCFG)
      begin
        if (avs_read)
        begin
          d.rdata[15:0] = rd_tcfg;
        end
        else
        begin
          if (wmask[15])
          begin
            d.tx_off = wnew[SFD_TCFG_TX_LSB +: 3];
            d.rx_off = wnew[SFD_TCFG_RX_LSB +: 3];
            d.err_sel = wnew[SFD_TCFG_ERR_LSB +: 2];
          end
          if (wmask[0])
          begin
            d.tcfg_low = wnew[7:0];
          end
        end
      end
      else if (avs_address == SFD_ADDR_PHASE)
      begin
        if (avs_read)
        begin
          d.rdata[15:0] = rd_phase;
        end
        else if (wmask[0])
        begin
          // 4 bits hold at most 15, so one subtraction is the modulo
          if (ph_w > SFD_PH_MAX)
          begin
            d.ph_val = ph_w - SFD_PH_MAX;
          end
          else
          begin
            d.ph_val = ph_w;
          end
          d.ph_en = wnew[SFD_PH_EN_BIT];
        end
      end
    end

    // enable applies the stored value one cycle after the write
    if (q.ph_en)
    begin
      d.ph_app = q.ph_val;
    end

    // free divider locked to ref_clk; phase only moves via ph_app
    d.div_cnt = DIV_W'(q.div_cnt + 1'b1);
    d.clk_out = DIV_W'(q.div_cnt + sfd_ph_cycles(q.ph_app))
      < DIV_W'(TXCLK_DIV / 2);

    // toggle crossing, bit 0 is the first stage and feeds only bit 1
    d.tx_sync = {q.tx_sync[1:0], lq.tx_tgl};
    d.rx_sync = {q.rx_sync[1:0], lq.rx_tgl};
    d.tx_dly = {q.tx_dly[SFD_DLY_TAPS-2:0], q.tx_sync[2] ^ q.tx_sync[1]};
    d.rx_dly = {q.rx_dly[SFD_DLY_TAPS-2:0], q.rx_sync[2] ^ q.rx_sync[1]};
    tx_pulse = q.tx_dly[sfd_dly_cycles(q.tx_off)];
    rx_pulse = q.rx_dly[sfd_dly_cycles(q.rx_off)];

    // pin order: act, speed, link, crs, col, pdint
    d.pin_o[0] = sfd_route(SFD_PIN_ACT, q.tx_sel, q.rx_sel,
      tx_pulse, rx_pulse, act_fn);
    d.pin_o[1] = sfd_route(SFD_PIN_SPEED, q.tx_sel, q.rx_sel,
      tx_pulse, rx_pulse, speed_fn);
    d.pin_o[2] = sfd_route(SFD_PIN_LINK, q.tx_sel, q.rx_sel,
      tx_pulse, rx_pulse, link_fn);
    d.pin_o[3] = sfd_route(SFD_PIN_CRS, q.tx_sel, q.rx_sel,
      tx_pulse, rx_pulse, crs_fn);
    d.pin_o[4] = sfd_route(SFD_PIN_COL, q.tx_sel, q.rx_sel,
      tx_pulse, rx_pulse, col_fn);
    d.pin_o[5] = sfd_route(SFD_PIN_PDINT, q.tx_sel, q.rx_sel,
      tx_pulse, rx_pulse, pdint_fn);

    // a pin chosen as tx error input stops driving
    d.pin_oe[0] = (q.err_sel != SFD_ERR_ACT);
    d.pin_oe[1] = (q.err_sel != SFD_ERR_COL);
    d.pin_oe[2] = (q.err_sel != SFD_ERR_POWERDOWN_PIN);
    d.err_s1 = {powerdown_interrupt_pin_i, col_pin_i, activity_led_pin_i};
    d.err_s2 = q.err_s1;
    if (q.err_sel == SFD_ERR_ACT)
    begin
      d.err_out = q.err_s2[0];
    end
    else if (q.err_sel == SFD_ERR_COL)
    begin
      d.err_out = q.err_s2[1];
    end
    else if (q.err_sel == SFD_ERR_POWERDOWN_PIN)
    begin
      d.err_out = q.err_s2[2];
    end
    else
    begin
      d.err_out = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q <= '0;
      q.wait_q <= 1'b1;
      q.tx_sel <= SFD_PSEL_RST;
      q.rx_sel <= SFD_PSEL_RST;
      q.tx_off <= SFD_OFF_RST;
      q.rx_off <= SFD_OFF_RST;
      q.err_sel <= TXERR_TRIM;
      q.tcfg_low <= SFD_TCFG_LOW_RST;
      q.ph_val <= SFD_PH_RST;
      q.ph_app <= SFD_PH_RST;
      q.pin_oe <= '1;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wait_q;
  assign activity_led_pin_o = q.pin_o[0];
  assign speed_led_pin_o = q.pin_o[1];
  assign link_led_pin_o = q.pin_o[2];
  assign crs_pin_o = q.pin_o[3];
  assign col_pin_o = q.pin_o[4];
  assign powerdown_interrupt_pin_o = q.pin_o[5];
  assign activity_led_pin_oe = q.pin_oe[0];
  assign col_pin_oe = q.pin_oe[1];
  assign powerdown_interrupt_pin_oe = q.pin_oe[2];
  assign tx_err = q.err_out;
  assign tx_clk = q.clk_out;
  assign tx_phase_applied = q.ph_app;
endmodule : sfd_timing_and_txclk_phase
`default_nettype wire

// ==== tb/sfd_props.sv ====
// checker: bus handshake, reserved bits, phase apply, tx error pin
// bound to the top module, sees its ports only
`timescale 1ns/1ns
`default_nettype none
module sfd_props
  import sfd_pkg::*;
#(
  parameter logic [1:0] TXERR_TRIM = 2'h0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic col_pin_i,
  input wire logic col_pin_oe,
  input wire logic tx_err,
  input wire logic tx_clk,
  input wire logic [3:0] tx_phase_applied
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic tk;
  logic ph_go;
  logic cf_go;
  logic rd_ok;
  logic [3:0] ph_q;
  logic [3:0] pa_q;
  logic [3:0] age_q;
  logic [1:0] es_q;
  logic [2:0] up_q;
  assign tk = (avs_read | avs_write) & avs_waitrequest;
  assign rd_ok = avs_read & !avs_waitrequest;
  assign ph_go = tk & avs_write & avs_byteenable[0] & avs_writedata[4]
    & (avs_address == SFD_ADDR_PHASE);
  assign cf_go = tk & avs_write & avs_byteenable[1]
    & (avs_address == SFD_ADDR_TCFG);
  // ages saturate so a long idle never wraps into a false window
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      es_q <= TXERR_TRIM;
      age_q <= 4'h0;
      pa_q <= 4'h7;
      ph_q <= 4'h0;
      up_q <= 3'h0;
    end
    else
    begin
      up_q <= up_q == 3'h7 ? up_q : up_q + 3'h1;
      if (cf_go)
        es_q <= avs_writedata[9:8];
      age_q <= cf_go ? 4'h0 : (age_q == 4'hF ? age_q : age_q + 4'h1);
      pa_q <= ph_go ? 4'h0 : (pa_q == 4'h7 ? pa_q : pa_q + 4'h1);
      if (ph_go)
        ph_q <= avs_writedata[3:0] > SFD_PH_MAX ?
          avs_writedata[3:0] - SFD_PH_MAX : avs_writedata[3:0];
    end
  end
  a_wait_answer: assert property (tk |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_rdata_upper: assert property (rd_ok |-> avs_readdata[31:16] == '0)
    else $error("upper read half not zero");
  a_psel_resv: assert property (rd_ok && avs_address == SFD_ADDR_PSEL
    |-> avs_readdata[15:7] == '0 && !avs_readdata[3])
    else $error("pin select reserved bits set");
  a_phase_resv: assert property (rd_ok && avs_address == SFD_ADDR_PHASE
    |-> avs_readdata[15:5] == '0)
    else $error("phase reserved bits set");
  a_phase_range: assert property (rd_ok && avs_address == SFD_ADDR_PHASE
    |-> avs_readdata[3:0] <= SFD_PH_MAX)
    else $error("stored phase above ten");
  a_phase_apply: assert property (ph_go |=> ##[1:2] tx_phase_applied == ph_q)
    else $error("phase not applied");
  a_phase_still: assert property ($changed(tx_phase_applied) |-> pa_q < 4'h4)
    else $error("phase moved without enable");
  a_err_follow: assert property (age_q > 4'h6 && es_q == SFD_ERR_COL
    |-> tx_err == $past(col_pin_i, 3))
    else $error("tx error does not follow col pin");
  a_err_oe: assert property (age_q > 4'h2 && es_q == SFD_ERR_COL |-> !col_pin_oe)
    else $error("col pin driven while used as input");
  // divider gives 1100 pattern, so two cycles back is inverse while ph_app holds
  a_clk_period: assert property (up_q > 3'h3 && pa_q > 4'h4
    |-> tx_clk != $past(tx_clk, 2))
    else $error("tx clock not a quarter of ref clock");
  c_phase: cover property (ph_go);
  c_cfg: cover property (cf_go);
  c_err: cover property (es_q == SFD_ERR_COL && tx_err);
endmodule : sfd_props
bind sfd_timing_and_txclk_phase sfd_props #(.TXERR_TRIM(TXERR_TRIM)) u_sfd_props (
  .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .col_pin_i,
  .col_pin_oe, .tx_err, .tx_clk, .tx_phase_applied);
`default_nettype wire

// ==== tb/sfd_mac_model.sv ====
// far side model: mac marking each sent or received frame delimiter
// runs on link_clk; pulses are one link cycle wide
`timescale 1ns/1ns
`default_nettype none
module sfd_mac_model (
  input wire logic link_clk,
  output logic tx_sfd_seen,
  output logic rx_sfd_seen
);
  initial
  begin
    tx_sfd_seen = 1'b0;
    rx_sfd_seen = 1'b0;
  end
  task automatic frame(input logic rx);
    @(posedge link_clk);
    tx_sfd_seen <= !rx;
    rx_sfd_seen <= rx;
    @(posedge link_clk);
    tx_sfd_seen <= 1'b0;
    rx_sfd_seen <= 1'b0;
  endtask : frame
endmodule : sfd_mac_model
`default_nettype wire

// ==== tb/testbench.sv ====
// bench: avalon-mm register access, sfd routing and offsets, phase, tx error
// ref_clk 100 MHz, link_clk 6 ns; the mac model supplies sfd pulses
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sfd_pkg::*;
  logic ref_clk = 0;
  logic link_clk = 0;
  logic srst = 1;
  logic [9:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tx_sfd_seen;
  logic rx_sfd_seen;
  logic [5:0] fn = '0;
  logic [5:0] pins;
  logic [5:0] pins_q = '0;
  logic [2:0] drv = '0;
  logic act_oe;
  logic col_oe;
  logic pd_oe;
  logic tx_err;
  logic [3:0] tx_phase_applied;
  wire [2:0] pin_i = {col_oe ? pins[4] : drv[2], pd_oe ? pins[5] : drv[1],
    act_oe ? pins[0] : drv[0]};
  int mismatches = 0;
  int num_checks = 0;
  int cnt[6];
  int cyc = 0;
  int last_rise = 0;
  initial
    forever #5 ref_clk = ~ref_clk;
  initial
  begin
    #1;
    forever #3 link_clk = ~link_clk;
  end
  sfd_mac_model u_sfd_mac_model (.link_clk, .tx_sfd_seen, .rx_sfd_seen);
  sfd_timing_and_txclk_phase u_sfd_timing_and_txclk_phase (
    .ref_clk, .srst, .link_clk, .link_rst(srst), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .tx_sfd_seen, .rx_sfd_seen, .act_fn(fn[0]),
    .speed_fn(fn[1]), .link_fn(fn[2]), .crs_fn(fn[3]), .col_fn(fn[4]),
    .pdint_fn(fn[5]), .activity_led_pin_i(pin_i[0]),
    .activity_led_pin_o(pins[0]), .activity_led_pin_oe(act_oe),
    .speed_led_pin_o(pins[1]), .link_led_pin_o(pins[2]),
    .crs_pin_o(pins[3]), .col_pin_i(pin_i[2]), .col_pin_o(pins[4]),
    .col_pin_oe(col_oe), .powerdown_interrupt_pin_i(pin_i[1]),
    .powerdown_interrupt_pin_o(pins[5]),
    .powerdown_interrupt_pin_oe(pd_oe), .tx_err, .tx_clk(),
    .tx_phase_applied);
  always @(posedge ref_clk)
  begin
    cyc++;
    pins_q <= pins;
    for (int i = 0; i < 6; i++)
      if (pins[i] && !pins_q[i])
      begin
        cnt[i]++;
        last_rise = cyc;
      end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one idle cycle first, so back-to-back calls never drive twice per step
  task automatic bus(input logic wr, input logic [9:0] a,
    input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("bus answer", 0, n >= 50);
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [9:0] a,
    input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(nm, {16'h0000, e}, q);
  endtask : rdc
  task automatic sfd(input logic rx, input logic [2:0] code, output int lat);
    int t0;
    for (int i = 0; i < 6; i++)
      cnt[i] = 0;
    t0 = cyc;
    u_sfd_mac_model.frame(rx);
    repeat (30) @(posedge ref_clk);
    lat = last_rise - t0;
    for (int i = 0; i < 6; i++)
      chk("sfd pulses", 32'(code == 3'(i + 1)), cnt[i]);
  endtask : sfd
  initial
  begin
    int l0;
    int l7;
    logic [3:0] v;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rdc("psel reset", SFD_ADDR_PSEL, 16'h0000);
    rdc("tcfg reset", SFD_ADDR_TCFG, 16'hB444);
    rdc("phase reset", SFD_ADDR_PHASE, 16'h0000);
    wr(SFD_ADDR_PSEL, 16'hFFFF);
    rdc("psel reserved", SFD_ADDR_PSEL, 16'h0077);
    wr(SFD_ADDR_PHASE, 16'hFFEC);
    rdc("phase reserved", SFD_ADDR_PHASE, 16'h0002);
    chk("no apply", 0, tx_phase_applied);
    rdc("unmapped", 10'h3FC, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      v = i == 0 ? 4'h3 : (i == 1 ? 4'hA : (i == 2 ? 4'hB : 4'hF >> (i - 3)));
      wr(SFD_ADDR_PHASE, {12'h001, v});
      v = v > 4'hA ? v - 4'hA : v;
      rdc("phase value", SFD_ADDR_PHASE, {12'h000, v});
      chk("phase applied", v, tx_phase_applied);
    end
    for (int c = 1; c < 8; c++)
    begin
      wr(SFD_ADDR_PSEL, {9'h000, 3'(c), 4'h7});
      sfd(1'b0, 3'(c), l0);
      wr(SFD_ADDR_PSEL, {9'h000, 3'h7, 1'b0, 3'(c)});
      sfd(1'b1, 3'(c), l0);
    end
    for (int r = 0; r < 2; r++)
    begin
      wr(SFD_ADDR_PSEL, r ? 16'h0071 : 16'h0017);
      wr(SFD_ADDR_TCFG, 16'h0044);
      sfd(1'(r), 3'h1, l0);
      wr(SFD_ADDR_TCFG, r ? 16'h1C44 : 16'hE044);
      sfd(1'(r), 3'h1, l7);
      chk("offset step", 1, l7 - l0 >= 5 && l7 - l0 <= 7);
    end
    wr(SFD_ADDR_PSEL, 16'h0000);
    fn <= 6'h2A;
    repeat (3) @(posedge ref_clk);
    chk("normal pins", 6'h2A, pins);
    for (int s = 0; s < 4; s++)
    begin
      wr(SFD_ADDR_TCFG, {6'h2D, 2'(s), 8'h44});
      drv <= s == 0 ? 3'h7 : 3'h1 << (s - 1);
      repeat (6) @(posedge ref_clk);
      chk("tx err high", s != 0, tx_err);
      drv <= 3'h0;
      repeat (6) @(posedge ref_clk);
      chk("tx err low", 0, tx_err);
    end
    print_verdict();
  end
  initial
  begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
